// File: design/bsc_channel.sv
// One Bisync serial channel with registers, baud generator, transmitter, receiver and vectored interrupts.
// Operation
// R01 - Writing C0 to master control forces reset.
// R02 - Mode 10 gives x1, 16-bit sync.
// R03 - Encoding 0 gives NRZ, CRC preset zero.
// R04 - Transmit clock and clock pin follow generator.
// R05 - Generator runs from bus clock when 03.
// R06 - Transmit control 64 gives 8 bits, CRC-16.
// R07 - Receive control C1 enables receiver, 8 bits.
// R08 - Interrupt on first character and special conditions.
// R09 - Master control 09 enables interrupts, status vector.
// R10 - Vectors 28, 2A, 2C, 2E from base 20.
// R11 - Wait held low while transmit buffer full.
// R12 - Host stretches cycle while wait active.
// R13 - Host resets CRC, enables it first.
// R14 - Cleared CRC enable excludes that character.
// R15 - Cleared end latch appends CRC on underrun.
// R16 - Host waits five characters before disabling.
// R17 - Enabling receiver enters hunt, sets hunt bit.
// R18 - Sync match leaves hunt, arms first interrupt.
// R19 - CRC error valid two characters later.
// R20 - Overrun raises special condition, readable cause.
// R21 - Host issues error and service resets.
// R22 - Host resets service, rearms, reenters hunt.
// R23 - Received CRC mismatch recorded in status.
// R24 - CRC-16 polynomial, one bit per bit.
`timescale 1ns/1ps
module bsc_channel (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	// Interrupt and wait
	input wire logic intAck,
	output logic [7:0] intVector,
	output logic intReqN,
	output logic waitN,
	// Serial line
	output logic txd,
	input wire logic rxd,
	input wire logic clkPinIn,
	output logic clkPinOut,
	output logic clkPinOe
);
	typedef enum logic [3:0] {TX_IDLE = 4'b0001, TX_DATA = 4'b0010, TX_CRC = 4'b0100, TX_SYNC = 4'b1000} bsc_tx_t;
	typedef enum logic [2:0] {RX_OFF = 3'b001, RX_HUNT = 3'b010, RX_DATA = 3'b100} bsc_rx_t;

	logic [7:0] wr_r [16];
	logic [7:0] rdData_r, vector_r, txBuf_r, pend_r, rxBuf_r, asm_r;
	logic [15:0] brgCnt_r, txSh_r, hunt_r, curSh, transmit_crc_enable, rxCrc;
	logic [4:0] txCnt_r, curCnt;
	logic [2:0] rxCnt_r;
	logic brgOut_r, pinQ_r, txd_r, txLvl_r, rxPrev_r, clkOut_r, clkOe_r, waitN_r, intReqN_r;
	logic txFull_r, txBufCrc_r, pendV_r, txInc_r, curInc, eom_r, rxAv_r, ovr_r, armed_r;
	logic charDone_r, p0_r, p1_r, crcErr_r, rxIp_r, spIp_r, txIp_r, extIp_r, ius_r;
	logic wrCmd, hwRst, brgTick, bitTick, txRun, rxRun, rxBit, txLoad, charDone, huntMatch;
	logic crcTxClr, crcRxClr, eomClr, rdData, wrData, rxStart, huntCmd, txEmptied;
	logic [2:0] cmd, vecCode;
	logic [15:0] syncWord;
	bsc_tx_t txSt_r, curSt;
	bsc_rx_t rxSt_r;

	// ----------------------------------------------------------------
	// Register writes and commands
	// ----------------------------------------------------------------
	assign hwRst = regWr && regAddr == bsc_pkg::REG_MIC && regWrData[7:6] == bsc_pkg::HW_RESET; // [R01]
	assign wrCmd = regWr && regAddr == bsc_pkg::REG_CMD;
	assign cmd = regWrData[5:3];
	assign crcTxClr = hwRst || (wrCmd && regWrData[7:6] == bsc_pkg::CRC_RST_TX);
	assign crcRxClr = hwRst || (wrCmd && regWrData[7:6] == bsc_pkg::CRC_RST_RX);
	assign eomClr = wrCmd && regWrData[7:6] == bsc_pkg::CRC_RST_EOM;
	assign wrData = regWr && regAddr == bsc_pkg::REG_DATA;
	assign rdData = regRd && regAddr == bsc_pkg::REG_DATA;
	assign rxStart = regWr && regAddr == bsc_pkg::REG_RXC && regWrData[bsc_pkg::B_RXEN]
		&& !wr_r[bsc_pkg::REG_RXC][bsc_pkg::B_RXEN];
	assign huntCmd = regWr && regAddr == bsc_pkg::REG_RXC && regWrData[bsc_pkg::B_HUNT];
	assign syncWord = {wr_r[bsc_pkg::REG_SYNH], wr_r[bsc_pkg::REG_SYNL]};

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_wr
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
					wr_r[gi] <= bsc_pkg::REG_RESET;
				else if (hwRst)
					wr_r[gi] <= bsc_pkg::REG_RESET; // [R01]
				else if (regWr && regAddr == 4'(gi) && gi != bsc_pkg::REG_CMD && gi != bsc_pkg::REG_DATA)
					wr_r[gi] <= (gi == bsc_pkg::REG_RXC) ? {regWrData[7:5], 1'b0, regWrData[3:0]} : regWrData;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Baud-rate generator and bit clock
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			brgCnt_r <= 16'h0000;
			brgOut_r <= 1'b0;
			pinQ_r <= 1'b0;
			clkOut_r <= 1'b0;
			clkOe_r <= 1'b0;
		end
		else
		begin
			pinQ_r <= clkPinIn;
			if (wr_r[bsc_pkg::REG_GEN][1:0] != bsc_pkg::BRG_PCLK_RUN) // [R05]
			begin
				brgCnt_r <= {wr_r[bsc_pkg::REG_TCH], wr_r[bsc_pkg::REG_TCL]};
				brgOut_r <= 1'b0;
			end
			else if (brgCnt_r == 16'h0000)
			begin
				brgCnt_r <= {wr_r[bsc_pkg::REG_TCH], wr_r[bsc_pkg::REG_TCL]}; // [R05]
				brgOut_r <= ~brgOut_r;
			end
			else
				brgCnt_r <= brgCnt_r - 16'h0001;
			clkOut_r <= brgOut_r; // [R04]
			clkOe_r <= wr_r[bsc_pkg::REG_CLK][bsc_pkg::B_CLKOE]; // [R04]
		end
	end

	assign brgTick = wr_r[bsc_pkg::REG_GEN][1:0] == bsc_pkg::BRG_PCLK_RUN && brgCnt_r == 16'h0000 && !brgOut_r;
	assign bitTick = (wr_r[bsc_pkg::REG_CLK][4:3] == bsc_pkg::TXCLK_BRG) ? brgTick : (clkPinIn && !pinQ_r); // [R04]
	assign txRun = wr_r[bsc_pkg::REG_TXC][bsc_pkg::B_TXEN] && wr_r[bsc_pkg::REG_TXC][7:5] == 3'b011
		&& wr_r[bsc_pkg::REG_TXC][bsc_pkg::B_CRC16]; // [R06]
	assign rxRun = wr_r[bsc_pkg::REG_RXC][bsc_pkg::B_RXEN] && wr_r[bsc_pkg::REG_RXC][7:6] == bsc_pkg::CHAR8
		&& wr_r[bsc_pkg::REG_MODE][7:6] == bsc_pkg::CLK_X1 && wr_r[bsc_pkg::REG_MODE][5:4] == bsc_pkg::MODE_SYNC16
		&& wr_r[bsc_pkg::REG_MODE][3:2] == bsc_pkg::MODE_SYNCEN; // [R02] [R07]

	// ----------------------------------------------------------------
	// Transmit buffer and wait
	// ----------------------------------------------------------------
	assign txLoad = txRun && bitTick && txCnt_r == 5'd0 && txFull_r;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst || hwRst)
		begin
			txBuf_r <= 8'h00;
			txFull_r <= 1'b0;
			txBufCrc_r <= 1'b0;
			pend_r <= 8'h00;
			pendV_r <= 1'b0;
			waitN_r <= 1'b1;
		end
		else
		begin
			if (txLoad && pendV_r)
			begin
				txBuf_r <= pend_r;
				txBufCrc_r <= wr_r[bsc_pkg::REG_TXC][bsc_pkg::B_TRANSMIT_CRC_ENABLE];
				pendV_r <= 1'b0;
			end
			else if (txLoad)
				txFull_r <= 1'b0;
			if (wrData && (!txFull_r || (txLoad && !pendV_r)))
			begin
				txBuf_r <= regWrData;
				txBufCrc_r <= wr_r[bsc_pkg::REG_TXC][bsc_pkg::B_TRANSMIT_CRC_ENABLE]; // [R14]
				txFull_r <= 1'b1;
			end
			else if (wrData && wr_r[bsc_pkg::REG_IEN][bsc_pkg::B_WAITEN] && !wr_r[bsc_pkg::REG_IEN][bsc_pkg::B_WAITRX])
			begin
				pend_r <= regWrData;
				pendV_r <= 1'b1; // [R11]
			end
			waitN_r <= !((pendV_r && !txLoad) || (wrData && txFull_r && !txLoad
				&& wr_r[bsc_pkg::REG_IEN][bsc_pkg::B_WAITEN] && !wr_r[bsc_pkg::REG_IEN][bsc_pkg::B_WAITRX])); // [R11]
		end
	end

	// ----------------------------------------------------------------
	// Transmit shifter, CRC append and sync fill
	// ----------------------------------------------------------------
	always_comb
	begin
		curSh = txSh_r;
		curCnt = txCnt_r;
		curSt = txSt_r;
		curInc = txInc_r;
		if (txCnt_r == 5'd0)
		begin
			curCnt = bsc_pkg::WORD_BITS;
			curInc = 1'b0;
			if (txFull_r)
			begin
				curSh = {8'h00, txBuf_r};
				curCnt = bsc_pkg::DATA_BITS;
				curSt = TX_DATA;
				curInc = txBufCrc_r; // [R14]
			end
			else if (txSt_r == TX_DATA && !eom_r)
			begin
				curSh = transmit_crc_enable; // [R15]
				curSt = TX_CRC;
			end
			else
			begin
				curSh = syncWord;
				curSt = TX_SYNC;
			end
		end
	end

	assign txEmptied = txLoad && !pendV_r;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst || hwRst)
		begin
			txSh_r <= 16'h0000;
			txCnt_r <= 5'd0;
			txSt_r <= TX_IDLE;
			txInc_r <= 1'b0;
			txLvl_r <= 1'b1;
			txd_r <= 1'b1;
			eom_r <= bsc_pkg::EOM_RESET;
		end
		else
		begin
			if (eomClr)
				eom_r <= 1'b0;
			if (!txRun)
			begin
				txSt_r <= TX_IDLE;
				txCnt_r <= 5'd0;
				txd_r <= 1'b1;
			end
			else if (bitTick)
			begin
				txSh_r <= curSh >> 1;
				txCnt_r <= curCnt - 5'd1;
				txSt_r <= curSt;
				txInc_r <= curInc;
				if (txCnt_r == 5'd0 && !txFull_r)
					eom_r <= 1'b1; // [R15]
				if (wr_r[bsc_pkg::REG_ENC][6:5] == bsc_pkg::ENC_NRZI) // [R03]
				begin
					txLvl_r <= curSh[0] ? txLvl_r : ~txLvl_r;
					txd_r <= curSh[0] ? txLvl_r : ~txLvl_r;
				end
				else
					txd_r <= curSh[0]; // [R03]
			end
		end
	end

	bsc_crc16 u_transmit_crc_enable (
		.core_clk(core_clk),
		.rst(rst),
		.clear(crcTxClr),
		.presetOnes(wr_r[bsc_pkg::REG_ENC][bsc_pkg::B_PRESET]), // [R03]
		.shift(txRun && bitTick && curSt == TX_DATA && curInc), // [R14]
		.bitIn(curSh[0]),
		.crc_r(transmit_crc_enable)
	);

	// ----------------------------------------------------------------
	// Receiver: hunt, assembly, overrun and CRC check
	// ----------------------------------------------------------------
	assign rxBit = (wr_r[bsc_pkg::REG_ENC][6:5] == bsc_pkg::ENC_NRZI) ? (rxd == rxPrev_r) : rxd;
	assign huntMatch = {rxBit, hunt_r[15:1]} == syncWord;
	assign charDone = rxRun && bitTick && rxSt_r == RX_DATA && rxCnt_r == 3'd7;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst || hwRst)
		begin
			rxSt_r <= RX_OFF;
			hunt_r <= 16'h0000;
			asm_r <= 8'h00;
			rxCnt_r <= 3'd0;
			rxPrev_r <= 1'b1;
			rxBuf_r <= 8'h00;
			rxAv_r <= 1'b0;
			ovr_r <= 1'b0;
			charDone_r <= 1'b0;
			p0_r <= 1'b0;
			p1_r <= 1'b0;
			crcErr_r <= 1'b0;
		end
		else
		begin
			charDone_r <= charDone;
			if (!rxRun)
				rxSt_r <= RX_OFF;
			else if (rxStart || huntCmd || rxSt_r == RX_OFF)
				rxSt_r <= RX_HUNT; // [R17]
			else if (bitTick)
			begin
				rxPrev_r <= rxd;
				if (rxSt_r == RX_HUNT)
				begin
					hunt_r <= {rxBit, hunt_r[15:1]}; // [R17]
					if (huntMatch)
					begin
						rxSt_r <= RX_DATA; // [R18]
						rxCnt_r <= 3'd0;
					end
				end
				else
				begin
					asm_r <= {rxBit, asm_r[7:1]};
					rxCnt_r <= rxCnt_r + 3'd1;
				end
			end
			if (wrCmd && cmd == bsc_pkg::CMD_ERR_RST)
			begin
				ovr_r <= 1'b0;
				crcErr_r <= 1'b0;
			end
			if (rdData)
				rxAv_r <= 1'b0;
			if (charDone)
			begin
				rxBuf_r <= {rxBit, asm_r[7:1]};
				rxAv_r <= 1'b1;
				if (rxAv_r && !rdData)
					ovr_r <= 1'b1; // [R20]
			end
			if (charDone_r)
			begin
				p0_r <= rxCrc != 16'h0000; // [R23]
				p1_r <= p0_r;
				crcErr_r <= p1_r; // [R19]
			end
		end
	end

	bsc_crc16 u_rxCrc (
		.core_clk(core_clk),
		.rst(rst),
		.clear(crcRxClr || rxSt_r == RX_HUNT),
		.presetOnes(wr_r[bsc_pkg::REG_ENC][bsc_pkg::B_PRESET]),
		.shift(rxRun && bitTick && rxSt_r == RX_DATA && wr_r[bsc_pkg::REG_RXC][bsc_pkg::B_RXCRC]), // [R23]
		.bitIn(rxBit),
		.crc_r(rxCrc)
	);

	// ----------------------------------------------------------------
	// Interrupt sources, service and vector
	// ----------------------------------------------------------------
	always_comb
	begin
		if (spIp_r)
			vecCode = bsc_pkg::VEC_SP;
		else if (rxIp_r)
			vecCode = bsc_pkg::VEC_RX;
		else if (txIp_r)
			vecCode = bsc_pkg::VEC_TX;
		else
			vecCode = bsc_pkg::VEC_EXT;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst || hwRst)
		begin
			armed_r <= 1'b0;
			rxIp_r <= 1'b0;
			spIp_r <= 1'b0;
			txIp_r <= 1'b0;
			extIp_r <= 1'b0;
			ius_r <= 1'b0;
			vector_r <= 8'h00;
			intReqN_r <= 1'b1;
		end
		else
		begin
			if (wrCmd && cmd == bsc_pkg::CMD_NEXT_RX)
				armed_r <= 1'b1;
			if (wrCmd && cmd == bsc_pkg::CMD_RST_IUS)
				ius_r <= 1'b0;
			if (wrCmd && cmd == bsc_pkg::CMD_ERR_RST)
				spIp_r <= 1'b0;
			if (wrCmd && cmd == bsc_pkg::CMD_RST_TXIP)
				txIp_r <= 1'b0;
			if (wrCmd && cmd == bsc_pkg::CMD_RST_EXT)
				extIp_r <= 1'b0;
			if (rdData)
				rxIp_r <= 1'b0;
			if (rxRun && bitTick && rxSt_r == RX_HUNT && huntMatch)
				armed_r <= 1'b1; // [R18]
			if (charDone && (wr_r[bsc_pkg::REG_IEN][4:3] == bsc_pkg::RXI_ALL
				|| (wr_r[bsc_pkg::REG_IEN][4:3] == bsc_pkg::RXI_FIRST && armed_r)))
			begin
				rxIp_r <= 1'b1; // [R08]
				armed_r <= 1'b0;
			end
			if (charDone && rxAv_r && !rdData && wr_r[bsc_pkg::REG_IEN][4:3] != bsc_pkg::RXI_OFF)
				spIp_r <= 1'b1; // [R20]
			if (txEmptied && wr_r[bsc_pkg::REG_IEN][bsc_pkg::B_TXIE])
				txIp_r <= 1'b1;
			if (rxRun && bitTick && rxSt_r == RX_HUNT && huntMatch && wr_r[bsc_pkg::REG_IEN][bsc_pkg::B_EXTIE]
				&& wr_r[bsc_pkg::REG_EXT][bsc_pkg::B_SYNCIE])
				extIp_r <= 1'b1; // [R08]
			if (intAck)
			begin
				ius_r <= 1'b1;
				vector_r <= wr_r[bsc_pkg::REG_MIC][bsc_pkg::B_VIS]
					? {wr_r[bsc_pkg::REG_VEC][7:4], vecCode, wr_r[bsc_pkg::REG_VEC][0]}
					: wr_r[bsc_pkg::REG_VEC]; // [R09] [R10]
			end
			intReqN_r <= !(wr_r[bsc_pkg::REG_MIC][bsc_pkg::B_MIE] && !ius_r && !intAck
				&& (rxIp_r || spIp_r || txIp_r || extIp_r)); // [R09]
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rdData_r <= 8'h00;
		else if (!regRd)
			rdData_r <= 8'h00;
		else if (regAddr == bsc_pkg::REG_LSTAT)
			rdData_r <= ({7'h00, rxAv_r} << bsc_pkg::S_RXAV) | ({7'h00, !txFull_r} << bsc_pkg::S_TXEMPTY)
				| ({7'h00, rxSt_r != RX_DATA} << bsc_pkg::S_HUNT) | ({7'h00, eom_r} << bsc_pkg::S_EOM); // [R17]
		else if (regAddr == bsc_pkg::REG_SPST)
			rdData_r <= ({7'h00, txSt_r != TX_DATA && !txFull_r} << bsc_pkg::S_SENT)
				| ({7'h00, ovr_r} << bsc_pkg::S_OVR) | ({7'h00, crcErr_r} << bsc_pkg::S_CRCERR); // [R19] [R20]
		else if (regAddr == bsc_pkg::REG_VEC)
			rdData_r <= wr_r[bsc_pkg::REG_MIC][bsc_pkg::B_VIS]
				? {wr_r[bsc_pkg::REG_VEC][7:4], vecCode, wr_r[bsc_pkg::REG_VEC][0]} : wr_r[bsc_pkg::REG_VEC];
		else if (regAddr == bsc_pkg::REG_DATA)
			rdData_r <= rxBuf_r;
		else if (regAddr == bsc_pkg::REG_TCL || regAddr == bsc_pkg::REG_TCH || regAddr == bsc_pkg::REG_ENC)
			rdData_r <= wr_r[regAddr];
		else
			rdData_r <= 8'h00;
	end

	assign regRdData = rdData_r;
	assign intVector = vector_r;
	assign intReqN = intReqN_r;
	assign waitN = waitN_r;
	assign txd = txd_r;
	assign clkPinOut = clkOut_r;
	assign clkPinOe = clkOe_r;
endmodule

// File: design/bsc_crc16.sv
// Bit-serial CRC-16 generator and checker.
`timescale 1ns/1ps
module bsc_crc16 (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic clear,
	input wire logic presetOnes,
	input wire logic shift,
	input wire logic bitIn,
	// Result
	output logic [15:0] crc_r
);
	logic fb;

	assign fb = bitIn ^ crc_r[0];

	// ----------------------------------------------------------------
	// Shifts one bit per data bit, first bit in at the low end.
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			crc_r <= bsc_pkg::CRC_PRESET_ZERO;
		else if (clear)
			crc_r <= presetOnes ? bsc_pkg::CRC_PRESET_ONES : bsc_pkg::CRC_PRESET_ZERO;
		else if (shift)
			crc_r <= (crc_r >> 1) ^ (fb ? bsc_pkg::CRC16_POLY_REFL : 16'h0000); // [R24]
	end
endmodule

// File: design/bsc_pkg.sv
// Constants shared by the Bisync serial channel files.
package bsc_pkg;
	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_IEN = 4'h1;
	localparam logic [3:0] REG_VEC = 4'h2;
	localparam logic [3:0] REG_RXC = 4'h3;
	localparam logic [3:0] REG_MODE = 4'h4;
	localparam logic [3:0] REG_TXC = 4'h5;
	localparam logic [3:0] REG_SYNL = 4'h6;
	localparam logic [3:0] REG_SYNH = 4'h7;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam logic [3:0] REG_MIC = 4'h9;
	localparam logic [3:0] REG_ENC = 4'ha;
	localparam logic [3:0] REG_CLK = 4'hb;
	localparam logic [3:0] REG_TCL = 4'hc;
	localparam logic [3:0] REG_TCH = 4'hd;
	localparam logic [3:0] REG_GEN = 4'he;
	localparam logic [3:0] REG_EXT = 4'hf;
	localparam logic [3:0] REG_LSTAT = 4'h0;
	localparam logic [3:0] REG_SPST = 4'h1;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int B_RXEN = 0;
	localparam int B_RXCRC = 3;
	localparam int B_HUNT = 4;
	localparam int B_TRANSMIT_CRC_ENABLE = 0;
	localparam int B_CRC16 = 2;
	localparam int B_TXEN = 3;
	localparam int B_MIE = 3;
	localparam int B_VIS = 0;
	localparam int B_EXTIE = 0;
	localparam int B_TXIE = 1;
	localparam int B_RXMODE = 3;
	localparam int B_WAITRX = 5;
	localparam int B_WAITEN = 7;
	localparam int B_PRESET = 7;
	localparam int B_ENC = 5;
	localparam int B_CLKOE = 2;
	localparam int B_TXCLK = 3;
	localparam int B_BRGEN = 0;
	localparam int B_BRGSRC = 1;
	localparam int B_SYNCIE = 4;
	localparam int B_SYNC = 4;
	localparam int B_CLKMODE = 6;
	localparam int B_CHBITS = 6;
	localparam int S_RXAV = 0;
	localparam int S_TXEMPTY = 2;
	localparam int S_HUNT = 4;
	localparam int S_EOM = 6;
	localparam int S_SENT = 0;
	localparam int S_OVR = 5;
	localparam int S_CRCERR = 6;
	// ----------------------------------------------------------------
	// Field codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] HW_RESET = 2'b11;
	localparam logic [1:0] MODE_SYNC16 = 2'b01;
	localparam logic [1:0] MODE_SYNCEN = 2'b00;
	localparam logic [1:0] CLK_X1 = 2'b00;
	localparam logic [1:0] CHAR8 = 2'b11;
	localparam logic [1:0] ENC_NRZ = 2'b00;
	localparam logic [1:0] ENC_NRZI = 2'b01;
	localparam logic [1:0] TXCLK_BRG = 2'b10;
	localparam logic [1:0] BRG_PCLK_RUN = 2'b11;
	localparam logic [1:0] RXI_FIRST = 2'b01;
	localparam logic [1:0] RXI_ALL = 2'b10;
	localparam logic [1:0] RXI_OFF = 2'b00;
	localparam logic [2:0] CMD_RST_EXT = 3'h2;
	localparam logic [2:0] CMD_NEXT_RX = 3'h4;
	localparam logic [2:0] CMD_RST_TXIP = 3'h5;
	localparam logic [2:0] CMD_ERR_RST = 3'h6;
	localparam logic [2:0] CMD_RST_IUS = 3'h7;
	localparam logic [1:0] CRC_RST_RX = 2'b01;
	localparam logic [1:0] CRC_RST_TX = 2'b10;
	localparam logic [1:0] CRC_RST_EOM = 2'b11;
	localparam logic [2:0] VEC_TX = 3'h4;
	localparam logic [2:0] VEC_EXT = 3'h5;
	localparam logic [2:0] VEC_RX = 3'h6;
	localparam logic [2:0] VEC_SP = 3'h7;
	localparam logic [15:0] CRC16_POLY_REFL = 16'ha001;
	localparam logic [15:0] CRC_PRESET_ONES = 16'hffff;
	localparam logic [15:0] CRC_PRESET_ZERO = 16'h0000;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic EOM_RESET = 1'b1;
	localparam logic [4:0] DATA_BITS = 5'd8;
	localparam logic [4:0] WORD_BITS = 5'd16;
endpackage

// File: testbench/bsc_channel_asserts.sv
// Concurrent checks on the Bisync serial channel ports.
`timescale 1ns/1ps
module bsc_channel_asserts (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	// Interrupt and wait
	input wire logic intAck,
	input wire logic [7:0] intVector,
	input wire logic intReqN,
	input wire logic waitN,
	// Serial line
	input wire logic txd,
	input wire logic rxd,
	input wire logic clkPinIn,
	input wire logic clkPinOut,
	input wire logic clkPinOe
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	logic micWr;
	logic clkWr;
	assign micWr = regWr && regAddr == bsc_pkg::REG_MIC;
	assign clkWr = regWr && regAddr == bsc_pkg::REG_CLK && regWrData[bsc_pkg::B_CLKOE];
	sequence sHwReset;
		micWr && regWrData == 8'hc0;
	endsequence
	sequence sBlocked;
		regWr && regAddr == bsc_pkg::REG_DATA ##1 !waitN;
	endsequence
	AST_RESET_IDLE: assert property ($fell(rst) |-> txd && intReqN && waitN && !clkPinOe)
		else $error("outputs not idle after reset");
	AST_HW_RESET: assert property (sHwReset |-> ##3 intReqN && waitN && !clkPinOe)
		else $error("state kept after forced reset");
	AST_WAIT_CAUSE: assert property ($fell(waitN) |-> $past(regWr && regAddr == bsc_pkg::REG_DATA))
		else $error("wait without data write");
	AST_WAIT_END: assert property (sBlocked |-> ##[1:1000] waitN)
		else $error("wait never released");
	AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 8'h00)
		else $error("read data outside answer cycle");
	AST_VEC_HOLD: assert property (!$past(intAck) && !$past(micWr) && !$past(micWr, 2) |-> $stable(intVector))
		else $error("vector changed without acknowledge");
	AST_VEC_CODE: assert property (intAck && !intReqN |=> intVector[3])
		else $error("vector code out of range");
	AST_CLK_OE: assert property ($rose(clkPinOe) |-> $past(clkWr) || $past(clkWr, 2))
		else $error("clock pin enabled without write");
endmodule
bind bsc_channel bsc_channel_asserts u_chk (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .intAck(intAck),
	.intVector(intVector), .intReqN(intReqN), .waitN(waitN), .txd(txd), .rxd(rxd),
	.clkPinIn(clkPinIn), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe));

// File: testbench/bsc_channel_test.sv
// Self-checking testbench for the Bisync serial channel.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module bsc_channel_test;
	// ------------------------------------------------------------
	// Bench signals and instances
	// ------------------------------------------------------------
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] regAddr = '0;
	logic [7:0] regWrData = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic intAck = 1'b0;
	logic [7:0] regRdData, intVector, d;
	logic intReqN, waitN, txd, rxd, clkPinOut, clkPinOe, clkPin, hit;
	logic [47:0] target = '0;
	logic [15:0] c;
	int err_count = 0;
	int total_checks = 0;
	always #25 core_clk = ~core_clk;
	assign clkPin = clkPinOe ? clkPinOut : 1'b0;
	bsc_channel u_dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .intAck(intAck), .intVector(intVector),
		.intReqN(intReqN), .waitN(waitN), .txd(txd), .rxd(rxd), .clkPinIn(clkPin),
		.clkPinOut(clkPinOut), .clkPinOe(clkPinOe));
	bsc_remote_station u_st (.bitClk(clkPin), .txd(txd), .rxd(rxd), .target(target), .hit(hit));
	// ------------------------------------------------------------
	// Bus tasks and scenarios
	// ------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(negedge core_clk);
		d = regRdData;
	endtask
	task automatic ack();
		@(posedge core_clk);
		intAck <= 1'b1;
		@(posedge core_clk);
		intAck <= 1'b0;
		@(negedge core_clk);
	endtask
	task automatic rx_byte();
		rd(bsc_pkg::REG_LSTAT);
		for (int i = 0; i < 300 && d[0] !== 1'b1; i++)
			rd(bsc_pkg::REG_LSTAT);
		rd(bsc_pkg::REG_DATA);
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 2000 && intReqN !== 1'b0; i++)
			@(negedge core_clk);
	endtask
	task automatic t_init();
		logic [11:0] tbl [15];
		realtime t0;
		tbl = '{12'h9c0, 12'h410, 12'ha00, 12'h6ab, 12'h7cd, 12'h220, 12'hb16, 12'hcce,
			12'hd00, 12'he03, 12'hf00, 12'h564, 12'h3c1, 12'h108, 12'h909};
		foreach (tbl[i])
			wr(tbl[i][11:8], tbl[i][7:0]);
		rd(bsc_pkg::REG_TCL);
		`CHK("time constant", 8'hce, d)
		rd(bsc_pkg::REG_TXC);
		`CHK("unmapped read", 8'h00, d)
		rd(bsc_pkg::REG_LSTAT);
		`CHK("hunt bit", 1'b1, d[bsc_pkg::S_HUNT])
		`CHK("clock pin enable", 1'b1, clkPinOe)
		@(posedge clkPin);
		t0 = $realtime;
		@(posedge clkPin);
		`CHK("bit period", 414, int'(($realtime - t0) / 50.0))
		wr(bsc_pkg::REG_TCL, 8'h03);
		$display("test init done");
	endtask
	task automatic t_tx();
		c = u_st.calc(u_st.calc(16'h0000, 8'h02), 8'h31);
		target = {8'hcd, 8'hab, c[15:8], c[7:0], 8'h31, 8'h02};
		wr(bsc_pkg::REG_IEN, 8'h88);
		wr(bsc_pkg::REG_CMD, 8'h80);
		wr(bsc_pkg::REG_TXC, 8'h6d);
		// Lets the old time constant run out and the second sync fill start, so both data writes land in one fill.
		repeat (440) @(posedge core_clk);
		wr(bsc_pkg::REG_DATA, 8'h02);
		wr(bsc_pkg::REG_DATA, 8'h31);
		@(negedge core_clk);
		`CHK("wait asserted", 1'b0, waitN)
		for (int i = 0; i < 200 && waitN !== 1'b1; i++)
			@(negedge core_clk);
		`CHK("wait released", 1'b1, waitN)
		wr(bsc_pkg::REG_CMD, 8'hc0);
		for (int i = 0; i < 2000 && hit !== 1'b1; i++)
			@(negedge core_clk);
		`CHK("frame on line", 1'b1, hit)
		rd(bsc_pkg::REG_LSTAT);
		`CHK("end latch", 1'b1, d[bsc_pkg::S_EOM])
		repeat (320) @(negedge core_clk);
		wr(bsc_pkg::REG_TXC, 8'h64);
		wr(bsc_pkg::REG_IEN, 8'h08);
		$display("test tx done");
	endtask
	task automatic t_rx(input logic bad);
		fork
			u_st.send_frame(8'h02, 8'h31, bad);
		join_none
		wait_irq();
		`CHK("first char request", 1'b0, intReqN)
		rd(bsc_pkg::REG_LSTAT);
		`CHK("hunt left", 1'b0, d[bsc_pkg::S_HUNT])
		ack();
		`CHK("rx vector", 8'h2c, intVector)
		rd(bsc_pkg::REG_DATA);
		`CHK("first char", 8'h02, d)
		rx_byte();
		`CHK("second char", 8'h31, d)
		repeat (4) rx_byte();
		rd(bsc_pkg::REG_SPST);
		`CHK("crc error", bad, d[bsc_pkg::S_CRCERR])
		wr(bsc_pkg::REG_CMD, 8'h30);
		wr(bsc_pkg::REG_CMD, 8'h38);
		wr(bsc_pkg::REG_CMD, 8'h20);
		wr(bsc_pkg::REG_RXC, 8'hd9);
		$display("test rx done");
	endtask
	task automatic t_ovr();
		fork
			u_st.send_frame(8'h02, 8'h31, 1'b0);
		join_none
		wait_irq();
		ack();
		rd(bsc_pkg::REG_DATA);
		wr(bsc_pkg::REG_CMD, 8'h38);
		wait_irq();
		ack();
		`CHK("special vector", 8'h2e, intVector)
		rd(bsc_pkg::REG_SPST);
		`CHK("overrun", 1'b1, d[bsc_pkg::S_OVR])
		wr(bsc_pkg::REG_CMD, 8'h30);
		wr(bsc_pkg::REG_CMD, 8'h38);
		@(negedge core_clk);
		`CHK("request cleared", 1'b1, intReqN)
		$display("test overrun done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		t_init();
		wr(bsc_pkg::REG_RXC, 8'hc9);
		t_tx();
		t_rx(1'b0);
		t_rx(1'b1);
		t_ovr();
		complete_run();
	end
	initial
	begin
		repeat (30000) @(posedge core_clk);
		err_count++;
		complete_run();
	end
endmodule

// File: testbench/bsc_remote_station.sv
// Remote Bisync station model on the far end of the serial line.
`timescale 1ns/1ps
module bsc_remote_station (
	// Line
	input wire logic bitClk,
	input wire logic txd,
	output logic rxd,
	// Pattern watch
	input wire logic [47:0] target,
	output logic hit
);
	// ------------------------------------------------------------
	// Line behaviour
	// ------------------------------------------------------------
	logic [47:0] hist = '0;
	logic busy = 1'b0;
	initial rxd = 1'b1;
	initial hit = 1'b0;
	// Idle line changes every bit, captured bits are matched.
	always @(negedge bitClk)
	begin
		if (!busy)
			rxd <= ~rxd;
		hist <= {txd, hist[47:1]};
		if ({txd, hist[47:1]} == target)
			hit <= 1'b1;
	end
	function automatic logic [15:0] calc(input logic [15:0] c, input logic [7:0] b);
		logic fb;
		for (int i = 0; i < 8; i++)
		begin
			fb = c[0] ^ b[i];
			c = c >> 1;
			if (fb)
				c = c ^ 16'ha001;
		end
		return c;
	endfunction
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge bitClk);
			rxd <= b[i];
		end
	endtask
	task automatic send_frame(input logic [7:0] d0, input logic [7:0] d1, input logic bad);
		logic [15:0] c;
		c = calc(calc(16'h0000, d0), d1);
		busy = 1'b1;
		send_byte(8'hab);
		send_byte(8'hcd);
		send_byte(d0);
		send_byte(d1);
		send_byte(c[7:0]);
		send_byte(c[15:8] ^ {7'h00, bad});
		repeat (2) send_byte(8'h55);
		@(negedge bitClk);
		busy = 1'b0;
	endtask
endmodule
